/* rtl/blcp_defs.svh */
// register offsets, reset values and command codes of the boot command port
`ifndef BLCP_DEFS_SVH
`define BLCP_DEFS_SVH
`define BLCP_APPID_BOOT 8'h80
`define BLCP_OFS_CMD_STAT 8'h08
`define BLCP_OFS_LEN 8'h09
`define BLCP_OFS_DATA_FIRST 8'h0a
`define BLCP_OFS_DATA_LAST 8'h8a
`define BLCP_OFS_CSUM 8'h8b
`define BLCP_LEN_MSB 6
`define BLCP_LEN_MAX 8'h80
`define BLCP_CSUM_XOR 8'hff
`define BLCP_RST_BYTE 8'h00
`define BLCP_CMD_REMAP 8'h11
`define BLCP_CMD_DL_INIT 8'h14
`define BLCP_CMD_WR_RAM 8'h41
`define BLCP_CMD_ADDR_RAM 8'h43
`define BLCP_LEN_DL_INIT 8'h01
`define BLCP_LEN_ADDR_RAM 8'h02
`define BLCP_LEN_REMAP 8'h00
`define BLCP_ST_OK 8'h00
`define BLCP_ST_BUSY 8'h01
`define BLCP_ST_BAD_CSUM 8'h02
`define BLCP_ST_BAD_CMD 8'h03
`define BLCP_ST_BAD_LEN 8'h04
`endif

/* rtl/blcp_pkg.sv */
// types of the boot command port
package blcp_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        BLCP_IDLE,
        BLCP_SUM,
        BLCP_EXEC,
        BLCP_WRITE
    } blcp_state_t;
endpackage : blcp_pkg

/* rtl/blcp_boot_port.sv */
// boot loader command interpreter behind the register mailbox
// Overview of operation
// - registers visible only while selector is 0x80
// - write 0x08 issues command, read gives status
// - length register bits 6:0, up to 0x7f
// - payload bytes at 0x0a to 0x8a
// - checksum is inverted byte sum of frame
// - 0x11 remaps ram and requests system reset
// - remap and restart happens at once
// - 0x14 loads seed, arms download hardware
// - 0x41 writes payload into ram at pointer
// - pointer moves past last written byte
// - 0x43 loads pointer from two-byte payload
// - pointer payload low byte first
// - mailbox registers reset to zero
`timescale 1ns/100ps
`include "blcp_defs.svh"
module blcp_boot_port #(
    parameter int ADDR_W = 16,  // ram pointer width
    parameter int DEPTH = 128   // payload bytes
) (
    input wire logic clk,                  // module clock
    input wire logic sys_rst,              // async reset, active high
    input wire logic [7:0] app_select,     // application selector value
    input wire logic reg_wr,               // register write strobe
    input wire logic reg_rd,               // register read strobe
    input wire logic [7:0] reg_addr,       // register byte address
    input wire logic [7:0] reg_wdata,      // register write data
    output logic [7:0] reg_rdata,          // register read data
    output logic ram_we,                   // ram byte write strobe
    output logic [ADDR_W-1:0] ram_addr,    // ram byte address
    output logic [7:0] ram_wdata,          // ram byte data
    output logic remap_ram,                // ram mapped at address zero
    output logic sys_reset_req,            // one-cycle system reset request
    output logic dl_init,                  // one-cycle download arm pulse
    output logic [7:0] dl_seed,            // seed for download hardware
    output logic [ADDR_W-1:0] ram_ptr      // current ram pointer
);
    import blcp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // mailbox storage and decode
    logic [7:0] cmd_r;            // command code last written
    logic [7:0] stat_r;           // status returned on read
    logic [6:0] len_r;            // payload length
    logic [7:0] data_r [DEPTH+1]; // payload window, one byte past the last payload slot
    logic [7:0] csum_r;           // checksum byte
    logic [7:0] sum_r;            // running byte sum
    logic [7:0] idx_r;            // payload walk index
    blcp_state_t state_r;         // sequencer state
    logic [ADDR_W-1:0] ptr_r;     // ram pointer
    logic boot_sel;               // boot loader registers exposed
    logic in_data;                // address falls in the payload area
    logic [7:0] data_ofs;         // payload index of the address
    logic busy;                   // sequencer running
    logic [7:0] len_ext;          // length widened to a byte
    logic sum_good;               // frame checksum matches

    assign boot_sel = (app_select == `BLCP_APPID_BOOT);
    assign in_data = (reg_addr >= `BLCP_OFS_DATA_FIRST) && (reg_addr <= `BLCP_OFS_DATA_LAST);
    assign data_ofs = reg_addr - `BLCP_OFS_DATA_FIRST;
    assign busy = (state_r != BLCP_IDLE);
    assign len_ext = {1'b0, len_r};

    ////////////////////////////////////////////////////////////////////////
    // command register, written by the host while idle
    // zero on reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= `BLCP_RST_BYTE;
        end else if (boot_sel && reg_wr && !busy && reg_addr == `BLCP_OFS_CMD_STAT) begin
            cmd_r <= reg_wdata;
        end
    end

    // length register, low seven bits only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            len_r <= 7'h00;
        end else if (boot_sel && reg_wr && !busy && reg_addr == `BLCP_OFS_LEN) begin
            len_r <= reg_wdata[`BLCP_LEN_MSB:0];
        end
    end

    // checksum register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            csum_r <= `BLCP_RST_BYTE;
        end else if (boot_sel && reg_wr && !busy && reg_addr == `BLCP_OFS_CSUM) begin
            csum_r <= reg_wdata;
        end
    end

    // payload bytes, one flip-flop byte per entry; the window ends one byte
    // past the largest payload so its top address stays readable and writable
    generate
        for (genvar i = 0; i < DEPTH + 1; i++) begin : g_data
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    data_r[i] <= `BLCP_RST_BYTE;
                end else if (boot_sel && reg_wr && !busy && in_data
                             && data_ofs == 8'(i)) begin
                    data_r[i] <= reg_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // sequencer: sum the frame, then act on the command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= BLCP_IDLE;
        end else begin
            unique case (state_r)
                // idle: a command write starts the checksum walk
                BLCP_IDLE: begin
                    if (boot_sel && reg_wr && reg_addr == `BLCP_OFS_CMD_STAT) begin
                        state_r <= BLCP_SUM;
                    end
                end
                // sum payload bytes one per cycle
                BLCP_SUM: begin
                    if (idx_r >= len_ext) begin
                        state_r <= BLCP_EXEC;
                    end
                end
                // decide; block write goes on to copy bytes
                BLCP_EXEC: begin
                    if (sum_good && cmd_r == `BLCP_CMD_WR_RAM && len_ext != 8'h00
                        && len_ext <= `BLCP_LEN_MAX) begin
                        state_r <= BLCP_WRITE;
                    end else begin
                        state_r <= BLCP_IDLE;
                    end
                end
                // copy payload into ram
                BLCP_WRITE: begin
                    if (idx_r + 8'h01 >= len_ext) begin
                        state_r <= BLCP_IDLE;
                    end
                end
            endcase
        end
    end

    // walk index over payload
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_r <= 8'h00;
        end else if (state_r == BLCP_SUM && idx_r < len_ext) begin
            idx_r <= idx_r + 8'h01;
        end else if (state_r == BLCP_WRITE) begin
            idx_r <= idx_r + 8'h01;
        end else begin
            idx_r <= 8'h00;
        end
    end

    // running sum; seeded with command and length
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_r <= 8'h00;
        end else if (state_r == BLCP_IDLE) begin
            sum_r <= reg_wdata + len_ext;
        end else if (state_r == BLCP_SUM && idx_r < len_ext) begin
            sum_r <= sum_r + data_r[idx_r[6:0]];
        end
    end

    // inverted sum must match checksum byte
    assign sum_good = ((sum_r ^ `BLCP_CSUM_XOR) == csum_r);

    // command code known with its proper length
    logic cmd_ok; // code and length agree
    always_comb begin
        unique case (cmd_r)
            `BLCP_CMD_REMAP: cmd_ok = (len_ext == `BLCP_LEN_REMAP);
            `BLCP_CMD_DL_INIT: cmd_ok = (len_ext == `BLCP_LEN_DL_INIT);
            `BLCP_CMD_WR_RAM: cmd_ok = (len_ext <= `BLCP_LEN_MAX);
            `BLCP_CMD_ADDR_RAM: cmd_ok = (len_ext == `BLCP_LEN_ADDR_RAM);
            default: cmd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // status register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_r <= `BLCP_RST_BYTE;
        end else if (state_r == BLCP_IDLE && boot_sel && reg_wr
                     && reg_addr == `BLCP_OFS_CMD_STAT) begin
            stat_r <= `BLCP_ST_BUSY;
        end else if (state_r == BLCP_EXEC) begin
            if (!sum_good) begin
                stat_r <= `BLCP_ST_BAD_CSUM;
            end else if (!cmd_ok) begin
                stat_r <= `BLCP_ST_BAD_CMD;
            end else if (cmd_r != `BLCP_CMD_WR_RAM || len_ext == 8'h00) begin
                stat_r <= `BLCP_ST_OK;
            end
        end else if (state_r == BLCP_WRITE && idx_r + 8'h01 >= len_ext) begin
            stat_r <= `BLCP_ST_OK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ram pointer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_r <= '0;
        end else if (state_r == BLCP_EXEC && sum_good && cmd_ok
                     && cmd_r == `BLCP_CMD_ADDR_RAM) begin
            ptr_r <= ADDR_W'({data_r[1], data_r[0]});
        end else if (state_r == BLCP_WRITE) begin
            ptr_r <= ptr_r + ADDR_W'(1);
        end
    end

    // ram write port
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= 8'h00;
        end else begin
            ram_we <= (state_r == BLCP_WRITE);
            ram_addr <= ptr_r;
            ram_wdata <= data_r[idx_r[6:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remap and restart
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            remap_ram <= 1'b0;
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= (state_r == BLCP_EXEC && sum_good && cmd_ok
                              && cmd_r == `BLCP_CMD_REMAP);
            if (state_r == BLCP_EXEC && sum_good && cmd_ok && cmd_r == `BLCP_CMD_REMAP) begin
                remap_ram <= 1'b1;
            end
        end
    end

    // seed and download arm pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dl_init <= 1'b0;
            dl_seed <= 8'h00;
        end else begin
            dl_init <= (state_r == BLCP_EXEC && sum_good && cmd_ok
                        && cmd_r == `BLCP_CMD_DL_INIT);
            if (state_r == BLCP_EXEC && sum_good && cmd_ok && cmd_r == `BLCP_CMD_DL_INIT) begin
                dl_seed <= data_r[0];
            end
        end
    end

    assign ram_ptr = ptr_r;

    ////////////////////////////////////////////////////////////////////////
    // read data, registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (!boot_sel) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == `BLCP_OFS_CMD_STAT) begin
                reg_rdata <= stat_r;
            end else if (reg_addr == `BLCP_OFS_LEN) begin
                reg_rdata <= len_ext;
            end else if (in_data) begin
                reg_rdata <= data_r[data_ofs];
            end else if (reg_addr == `BLCP_OFS_CSUM) begin
                reg_rdata <= csum_r;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule : blcp_boot_port

/* tb/blcp_boot_port_assertions.sv */
// assertion checker bound to the boot command port
`timescale 1ns/100ps
module blcp_port_chk #(parameter int ADDR_W = 16) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] app_select,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic ram_we,
    input wire logic [ADDR_W-1:0] ram_addr,
    input wire logic remap_ram,
    input wire logic sys_reset_req,
    input wire logic dl_init,
    input wire logic [7:0] dl_seed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // read of an address outside the mailbox while it is visible
    sequence s_hole;
        reg_rd && app_select == 8'h80 && (reg_addr < 8'h08 || reg_addr > 8'h8b);
    endsequence
    // two ram bytes written back to back
    sequence s_burst;
        ram_we ##1 ram_we;
    endsequence
    property p_hidden; reg_rd && app_select != 8'h80 |=> reg_rdata == 8'h00; endproperty
    a_hidden: assert property (p_hidden) else $error("hidden read not zero");
    property p_hole; s_hole |=> reg_rdata == 8'h00; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_step; s_burst |-> ram_addr == $past(ram_addr) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("ram address skipped");
    property p_pair; $rose(remap_ram) |-> sys_reset_req; endproperty
    a_pair: assert property (p_pair) else $error("remap without reset");
    property p_rst1; sys_reset_req |=> !sys_reset_req && remap_ram; endproperty
    a_rst1: assert property (p_rst1) else $error("reset request too long");
    property p_arm1; dl_init |=> !dl_init; endproperty
    a_arm1: assert property (p_arm1) else $error("arm pulse too long");
    property p_seed; $changed(dl_seed) |-> dl_init; endproperty
    a_seed: assert property (p_seed) else $error("seed moved without arm");
endmodule : blcp_port_chk
bind blcp_boot_port blcp_port_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .sys_rst(sys_rst),
    .app_select(app_select), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .ram_we(ram_we), .ram_addr(ram_addr), .remap_ram(remap_ram),
    .sys_reset_req(sys_reset_req), .dl_init(dl_init), .dl_seed(dl_seed));

/* tb/blcp_host_model.sv */
// host model doing byte accesses on the boot mailbox
`timescale 1ns/100ps
module blcp_host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, 16'h5a5a};
    // one access held for one edge; address and data inverted, strobes dropped once released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, ~w};
        @(posedge clk);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
        q = reg_rdata;
    endtask : xfer
endmodule : blcp_host_model

/* tb/blcp_boot_port_tb.sv */
// self-checking bench of the boot command port
`timescale 1ns/100ps
`include "blcp_defs.svh"
module blcp_boot_port_tb;
    logic clk, sys_rst, reg_wr, reg_rd, ram_we, remap_ram, sys_reset_req, dl_init;
    logic [7:0] app_select, reg_addr, reg_wdata, reg_rdata, ram_wdata, dl_seed, b;
    logic [15:0] ram_addr, ram_ptr;
    logic [15:0] ptr = 16'h0000;  // model ram pointer
    logic [31:0] rng = 32'h4b89;  // xorshift state
    logic [7:0] pl[128];  // payload of the next frame
    logic [7:0] ofs[4] = '{8'h08, 8'h09, 8'h0a, 8'h8b};
    int lens[4] = '{127, 1, 0, 2};  // block lengths, both ends of the range
    logic [23:0] exp_q[$];  // expected ram writes, address and byte
    int n_fail, samples_checked, cyc, n_dl, n_rst, exp_dl, exp_rst, i, k;
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    blcp_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    blcp_boot_port #(.ADDR_W(16), .DEPTH(128)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .app_select(app_select), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .remap_ram(remap_ram), .sys_reset_req(sys_reset_req),
        .dl_init(dl_init), .dl_seed(dl_seed), .ram_ptr(ram_ptr));
    // compare one result against the model
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // xorshift source of payload bytes
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction : rnd
    // register write, and read with comparison
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        host_u.xfer(1'b0, a, 8'h00, q);
        chk(24'(q), 24'(e));
    endtask : rdc
    // send one frame, poll status, check the model's view of ram, pointer and pulses
    task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] bad);
        logic [7:0] s, st;
        logic ok;
        int j;
        s = cmd + 8'(n);
        ok = bad == 8'h00 && (cmd == `BLCP_CMD_WR_RAM || cmd == `BLCP_CMD_ADDR_RAM && n == 2
            || cmd == `BLCP_CMD_DL_INIT && n == 1 || cmd == `BLCP_CMD_REMAP && n == 0);
        wr(`BLCP_OFS_LEN, 8'(n));
        for (j = 0; j < n; j++) begin
            wr(`BLCP_OFS_DATA_FIRST + 8'(j), pl[j]);
            s = s + pl[j];
            if (ok && cmd == `BLCP_CMD_WR_RAM) exp_q.push_back({ptr + 16'(j), pl[j]});
        end
        wr(`BLCP_OFS_CSUM, ~s ^ bad);
        wr(`BLCP_OFS_CMD_STAT, cmd);
        st = `BLCP_ST_BUSY;
        for (j = 0; j < 400 && st === `BLCP_ST_BUSY; j++) host_u.xfer(1'b0, 8'h08, 8'h00, st);
        if (ok && cmd == `BLCP_CMD_WR_RAM) ptr = ptr + 16'(n);
        if (ok && cmd == `BLCP_CMD_ADDR_RAM) ptr = {pl[1], pl[0]};
        exp_dl += int'(ok && cmd == `BLCP_CMD_DL_INIT);
        exp_rst += int'(ok && cmd == `BLCP_CMD_REMAP);
        chk(24'(st), 24'(bad != 0 ? `BLCP_ST_BAD_CSUM : ok ? `BLCP_ST_OK : `BLCP_ST_BAD_CMD));
        chk(24'(ram_ptr), 24'(ptr));
        chk(24'(exp_q.size()), 24'h0);
        chk({n_dl[7:0], n_rst[7:0], 8'(remap_ram)}, {exp_dl[7:0], exp_rst[7:0], 8'(exp_rst)});
        $display("test frame %h len %0d done", cmd, n);
    endtask : frame
    // verdict and end of run
    task automatic conclude();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // ram writes against the model, pulse counts, run limit
    always @(posedge clk) begin
        cyc++;
        if (ram_we === 1'b1) begin
            chk({ram_addr, ram_wdata}, exp_q.size() > 0 ? exp_q.pop_front() : 24'hx);
        end
        if (dl_init === 1'b1) n_dl++;
        if (sys_reset_req === 1'b1) n_rst++;
        if (cyc == 20000) begin
            n_fail++;
            $display("Error at %0t: timeout", $time);
            conclude();
        end
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        app_select = `BLCP_APPID_BOOT;
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (k = 0; k < 4; k++) rdc(ofs[k], 8'h00);
        chk(24'({remap_ram, dl_init, sys_reset_req, ram_we, ram_ptr}), 24'h0);
        $display("test reset values done");
        app_select = 8'h40;
        wr(`BLCP_OFS_LEN, 8'h15);
        rdc(`BLCP_OFS_LEN, 8'h00);
        app_select = `BLCP_APPID_BOOT;
        rdc(`BLCP_OFS_LEN, 8'h00);
        wr(`BLCP_OFS_LEN, 8'hff);
        rdc(`BLCP_OFS_LEN, 8'h7f);
        b = rnd();
        wr(`BLCP_OFS_DATA_LAST, b);
        rdc(`BLCP_OFS_DATA_LAST, b);
        rdc(8'h05, 8'h00);
        $display("test mailbox access done");
        {pl[0], pl[1]} = {rnd(), rnd()};
        frame(`BLCP_CMD_ADDR_RAM, 2, 8'h00);
        for (k = 0; k < 4; k++) begin
            for (i = 0; i < 128; i++) pl[i] = rnd();
            frame(`BLCP_CMD_WR_RAM, lens[k], 8'h00);
        end
        frame(`BLCP_CMD_WR_RAM, 3, 8'h01);
        frame(8'h42, 0, 8'h00);
        frame(`BLCP_CMD_ADDR_RAM, 1, 8'h00);
        frame(`BLCP_CMD_DL_INIT, 1, 8'h00);
        chk(24'(dl_seed), 24'(pl[0]));
        frame(`BLCP_CMD_REMAP, 0, 8'h00);
        // host recovers by a hardware reset after the restart
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk(24'({remap_ram, ram_ptr}), 24'h0);
        rdc(`BLCP_OFS_CMD_STAT, 8'h00);
        $display("test hardware recovery done");
        conclude();
    end
endmodule : blcp_boot_port_tb
